//--- rtl/phb_pkg.sv
// Shared constants, encodings and helpers for both ends of the PCI link.
package phb_pkg;
    // Core clock and the highest rate the PCI side may run at.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned PCI_MAX_HZ = 33_000_000;
    // The divide ratio rounds up so the bus never runs faster than allowed.
    localparam int unsigned PCI_DIV = (CLK_HZ + PCI_MAX_HZ - 1) / PCI_MAX_HZ;
    localparam logic [3:0] DIV_LAST = 4'(PCI_DIV - 1);

    // Software register addresses in the I/O space.
    localparam logic [15:0] CFG_SEL_ADDR = 16'h0CF8;
    localparam logic [15:0] CFG_DATA_ADDR = 16'h0CFC;
    localparam logic [15:0] CTRL_ADDR = 16'h0D00;
    localparam logic [15:0] BADDR_ADDR = 16'h0D04;
    localparam logic [15:0] WDATA_ADDR = 16'h0D08;
    localparam logic [15:0] RDATA_ADDR = 16'h0D0C;
    localparam logic [15:0] STAT_ADDR = 16'h0D10;
    // The data window seen as an ordinary I/O location.
    localparam logic [31:0] DATA_IO_ADDR = 32'h0000_0CFC;

    // Target select layout; reserved bits 30..24 always read zero.
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_WR_MASK = 32'h80FF_FFFF;
    localparam int SEL_EN_BIT = 31;
    localparam int SEL_DEV_LSB = 11;
    localparam int SEL_FN_LSB = 8;
    localparam int SEL_REG_LSB = 2;
    localparam logic [1:0] CYC_TYPE0 = 2'h0;
    localparam logic [1:0] CYC_TYPE1 = 2'h1;
    localparam logic [1:0] BURST_LINEAR = 2'h0;

    // Device n has its select line on address line IDSEL_BASE + n.
    localparam int IDSEL_BASE = 16;
    localparam int IDSEL_DEVS = 16;

    // Control register bits.
    localparam int CTRL_GO = 0;
    localparam int CTRL_MEM = 2;
    localparam int CTRL_WR = 1;
    localparam int CTRL_LEN_LSB = 4;

    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] DWORD_STEP = 32'h0000_0004;
    // Link cycles before a subtractive claim and before a master abort.
    localparam logic [3:0] SUB_WAIT = 4'h2;
    localparam logic [3:0] ABORT_WAIT = 4'h4;

    // Bus commands; every write command has bit 0 set.
    typedef enum logic [3:0] {
        CMD_SPECIAL = 4'h1,
        CMD_IO_RD = 4'h2,
        CMD_IO_WR = 4'h3,
        CMD_MEM_RD = 4'h6,
        CMD_MEM_WR = 4'h7,
        CMD_CFG_RD = 4'hA,
        CMD_CFG_WR = 4'hB
    } phb_cmd_t;

    // Address of the next data phase in a linear burst.
    function automatic logic [31:0] phb_next_addr(input logic [31:0] a);
        phb_next_addr = a + DWORD_STEP;
    endfunction

    // One-hot select line for a device number; none past the wired range.
    function automatic logic [31:0] phb_idsel(input logic [4:0] dev);
        phb_idsel = 32'h0000_0000;
        if (int'(dev) < IDSEL_DEVS)
        begin
            phb_idsel[IDSEL_BASE + int'(dev)] = 1'b1;
        end
    endfunction
endpackage

//--- rtl/phb_link_if.sv
// Link between the host bridge and a PCI agent, with the shared AD lines.
`timescale 1ns/100ps
interface phb_link_if;
    logic en;
    logic frame_n;
    logic irdy_n;
    logic devsel_n;
    logic trdy_n;
    logic [3:0] cmd;
    logic [31:0] idsel;
    logic [31:0] ad_h;
    logic ad_h_oe;
    logic [31:0] ad_a;
    logic ad_a_oe;
    logic [31:0] ad;

    // Resolved AD level; undriven lines float high as with pull-ups.
    assign ad = ad_a_oe ? ad_a : (ad_h_oe ? ad_h : 32'hFFFF_FFFF);

    modport host (
        output en, frame_n, irdy_n, cmd, idsel, ad_h, ad_h_oe,
        input devsel_n, trdy_n, ad
    );
    modport agent (
        input en, frame_n, irdy_n, cmd, idsel, ad,
        output devsel_n, trdy_n, ad_a, ad_a_oe
    );
endinterface

//--- rtl/phb_agent.sv
// PCI agent end: decodes its own cycles and holds config, I/O and memory.
`timescale 1ns/100ps
module phb_agent #(
    parameter logic [4:0] DEV_NUM = 5'h0E,           // Device number.
    parameter logic [31:0] IO_ADDR = 32'h0000_0300,  // Byte I/O address.
    parameter logic [31:0] MEM_BASE = 32'h000D_0000, // 64-byte window.
    parameter bit SUBTRACTIVE = 1'b0,                // Claim leftovers.
    parameter logic [31:0] ID_WORD = 32'h1234_5678   // Arbitrary value.
) (
    input wire logic core_clk_i,      // Core clock.
    input wire logic srst_i,          // Synchronous reset, high.
    phb_link_if.agent pci,            // Link to the host bridge.
    output logic [31:0] io_reg_o,     // I/O register contents.
    output logic [31:0] cfg_word1_o,  // Config dword 1 contents.
    output logic hit_o                // Pulse per completed data phase.
);
    typedef enum logic [1:0] {
        AG_IDLE = 2'b00,
        AG_WAIT = 2'b01,
        AG_DATA = 2'b11
    } phb_ag_st_t;

    typedef struct packed {
        phb_ag_st_t st;
        logic fr_q;
        logic [3:0] wt;
        logic [1:0] kind;
        logic wr;
        logic [31:0] addr;
        logic devsel_n;
        logic trdy_n;
        logic ad_oe;
        logic [31:0] ad;
        logic hit;
        logic [31:0] io_q;
        logic [15:0][31:0] cfg;
        logic [15:0][31:0] mem;
    } phb_ag_s_t;

    localparam logic [1:0] K_IO = 2'h0;
    localparam logic [1:0] K_MEM = 2'h1;
    localparam logic [1:0] K_CFG = 2'h2;

    phb_ag_s_t s_q;
    phb_ag_s_t s_d;
    logic is_io;
    logic is_mem;
    logic is_cfg;
    logic pos_hit;
    logic [1:0] pos_kind;

    // Positive decode of the address phase by this agent alone.
    always_comb
    begin
        is_io = pci.cmd == phb_pkg::CMD_IO_RD || pci.cmd == phb_pkg::CMD_IO_WR;
        is_mem = pci.cmd == phb_pkg::CMD_MEM_RD
            || pci.cmd == phb_pkg::CMD_MEM_WR;
        is_cfg = pci.cmd == phb_pkg::CMD_CFG_RD
            || pci.cmd == phb_pkg::CMD_CFG_WR;
        pos_hit = 1'b0;
        pos_kind = K_IO;
        if (is_cfg && pci.idsel[phb_pkg::IDSEL_BASE + int'(DEV_NUM)]
            && pci.ad[1:0] == phb_pkg::CYC_TYPE0)
        begin
            pos_hit = 1'b1;
            pos_kind = K_CFG;
        end
        else if (is_io && pci.ad == IO_ADDR)
        begin
            pos_hit = 1'b1;
        end
        else if (is_mem && pci.ad[31:6] == MEM_BASE[31:6]
            && pci.ad[1:0] == phb_pkg::BURST_LINEAR)
        begin
            pos_hit = 1'b1;
            pos_kind = K_MEM;
        end
    end

    // Agent sequence: claim, move data phases, release at the last one.
    always_comb
    begin
        s_d = s_q;
        s_d.hit = 1'b0;
        if (pci.en)
        begin
            s_d.fr_q = pci.frame_n;
            case (s_q.st)
                AG_IDLE:
                begin
                    if (!pci.frame_n && s_q.fr_q)
                    begin
                        s_d.wr = pci.cmd[0];
                        s_d.addr = pci.ad;
                        s_d.kind = pos_kind;
                        s_d.wt = 4'h0;
                        if (pos_hit)
                        begin
                            s_d.st = AG_WAIT;
                            s_d.wt = phb_pkg::SUB_WAIT;
                        end
                        else if (SUBTRACTIVE && (is_io || is_mem))
                        begin
                            s_d.st = AG_WAIT;
                            s_d.kind = is_mem ? K_MEM : K_IO;
                        end
                    end
                end
                AG_WAIT:
                begin
                    // Subtractive claim only after the positive window.
                    if (s_q.wt == phb_pkg::SUB_WAIT)
                    begin
                        s_d.st = AG_DATA;
                        s_d.devsel_n = 1'b0;
                        s_d.trdy_n = 1'b0;
                        s_d.ad_oe = !s_q.wr;
                        s_d.ad = s_q.kind == K_IO ? s_q.io_q
                            : (s_q.kind == K_CFG ? s_q.cfg[s_q.addr[5:2]]
                            : s_q.mem[s_q.addr[5:2]]);
                    end
                    else
                    begin
                        s_d.wt = s_q.wt + 4'h1;
                    end
                end
                AG_DATA:
                begin
                    if (!pci.irdy_n && !s_q.trdy_n)
                    begin
                        s_d.hit = 1'b1;
                        if (s_q.wr)
                        begin
                            case (s_q.kind)
                                K_IO: s_d.io_q = pci.ad;
                                K_CFG:
                                begin
                                    if (s_q.addr[5:2] != 4'h0)
                                    begin
                                        s_d.cfg[s_q.addr[5:2]] = pci.ad;
                                    end
                                end
                                default: s_d.mem[s_q.addr[5:2]] = pci.ad;
                            endcase
                        end
                        // Next dword of a linear burst.
                        s_d.addr = phb_pkg::phb_next_addr(s_q.addr);
                        s_d.ad = s_q.kind == K_IO ? s_q.io_q
                            : (s_q.kind == K_CFG ? s_q.cfg[s_d.addr[5:2]]
                            : s_q.mem[s_d.addr[5:2]]);
                        if (pci.frame_n)
                        begin
                            s_d.st = AG_IDLE;
                            s_d.devsel_n = 1'b1;
                            s_d.trdy_n = 1'b1;
                            s_d.ad_oe = 1'b0;
                        end
                    end
                end
                default: s_d.st = AG_IDLE;
            endcase
        end
    end

    // State register; config dword 0 always holds the identity word.
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
            s_q.fr_q <= 1'b1;
            s_q.devsel_n <= 1'b1;
            s_q.trdy_n <= 1'b1;
            s_q.cfg[0] <= ID_WORD;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pci.devsel_n = s_q.devsel_n;
    assign pci.trdy_n = s_q.trdy_n;
    assign pci.ad_a = s_q.ad;
    assign pci.ad_a_oe = s_q.ad_oe;
    assign io_reg_o = s_q.io_q;
    assign cfg_word1_o = s_q.cfg[1];
    assign hit_o = s_q.hit;
endmodule

//--- rtl/phb_host.sv
// Host bridge end: software registers, config mechanism and bus master.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module phb_host (
    input wire logic core_clk_i,      // Core clock.
    input wire logic srst_i,          // Synchronous reset, high.
    input wire logic [15:0] sw_addr_i,  // Register I/O address.
    input wire logic [31:0] sw_wdata_i, // Register write data.
    input wire logic sw_wr_i,         // Write strobe.
    input wire logic sw_rd_i,         // Read strobe.
    output logic [31:0] sw_rdata_o,   // Read data, cycle after strobe.
    phb_link_if.host pci              // Link to the agents.
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_APH = 3'b011,
        ST_DATA = 3'b010,
        ST_TURN = 3'b110
    } phb_host_st_t;

    typedef struct packed {
        phb_host_st_t st;
        logic [3:0] div;
        logic en;
        logic [31:0] sel;
        logic [31:0] baddr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [31:0] rd_o;
        logic [31:0] ad;
        logic [31:0] idsel;
        logic [3:0] cmd;
        logic [3:0] len;
        logic [3:0] wt;
        logic frame_n;
        logic irdy_n;
        logic ad_oe;
        logic busy;
        logic claimed;
        logic abort;
    } phb_host_s_t;

    phb_host_s_t s_q;
    phb_host_s_t s_d;
    logic go;
    logic [3:0] go_cmd;
    logic [31:0] go_addr;
    logic [31:0] go_idsel;
    logic [3:0] go_len;
    logic win_acc;
    logic win_wr;

    // Cycle that an access to the data window turns into.
    always_comb
    begin
        win_wr = sw_wr_i && sw_addr_i == phb_pkg::CFG_DATA_ADDR;
        win_acc = win_wr || (sw_rd_i && sw_addr_i == phb_pkg::CFG_DATA_ADDR);
        go = win_acc;
        go_len = 4'h0;
        go_idsel = 32'h0000_0000;
        if (s_q.sel[phb_pkg::SEL_EN_BIT])
        begin
            go_cmd = win_wr ? phb_pkg::CMD_CFG_WR : phb_pkg::CMD_CFG_RD;
            if (s_q.sel[1:0] == phb_pkg::CYC_TYPE0)
            begin
                // Special encoding has device 1Fh, so no line rises.
                go_idsel = phb_pkg::phb_idsel(
                    s_q.sel[phb_pkg::SEL_DEV_LSB +: 5]);
                go_addr = go_idsel
                    | {21'h0, s_q.sel[phb_pkg::SEL_FN_LSB +: 3],
                       s_q.sel[phb_pkg::SEL_REG_LSB +: 6],
                       phb_pkg::CYC_TYPE0};
            end
            else
            begin
                go_addr = {8'h00, s_q.sel[23:2], phb_pkg::CYC_TYPE1};
            end
        end
        else
        begin
            // Window behaves as an ordinary I/O port.
            go_cmd = win_wr ? phb_pkg::CMD_IO_WR : phb_pkg::CMD_IO_RD;
            go_addr = phb_pkg::DATA_IO_ADDR;
        end
        if (sw_wr_i && sw_addr_i == phb_pkg::CTRL_ADDR
            && sw_wdata_i[phb_pkg::CTRL_GO])
        begin
            // Processor I/O and memory accesses are forwarded here.
            go = 1'b1;
            go_addr = s_q.baddr;
            go_len = sw_wdata_i[phb_pkg::CTRL_LEN_LSB +: 4];
            case ({sw_wdata_i[phb_pkg::CTRL_MEM], sw_wdata_i[phb_pkg::CTRL_WR]})
                2'b00: go_cmd = phb_pkg::CMD_IO_RD;
                2'b01: go_cmd = phb_pkg::CMD_IO_WR;
                2'b10: go_cmd = phb_pkg::CMD_MEM_RD;
                default: go_cmd = phb_pkg::CMD_MEM_WR;
            endcase
            if (!sw_wdata_i[phb_pkg::CTRL_MEM])
            begin
                go_len = 4'h0;
            end
        end
    end

    // Register file, divider and bus master sequence.
    always_comb
    begin
        s_d = s_q;
        s_d.en = 1'b0;
        // Bus phases advance only on the divided enable.
        if (s_q.div == phb_pkg::DIV_LAST)
        begin
            s_d.div = 4'h0;
            s_d.en = 1'b1;
        end
        else
        begin
            s_d.div = s_q.div + 4'h1;
        end
        if (sw_wr_i)
        begin
            case (sw_addr_i)
                phb_pkg::CFG_SEL_ADDR:
                    s_d.sel = sw_wdata_i & phb_pkg::SEL_WR_MASK;
                // Window data is dropped while a cycle is running.
                phb_pkg::CFG_DATA_ADDR:
                    s_d.wdata = s_q.busy ? s_q.wdata : sw_wdata_i;
                phb_pkg::BADDR_ADDR: s_d.baddr = sw_wdata_i;
                phb_pkg::WDATA_ADDR: s_d.wdata = sw_wdata_i;
                default: s_d.baddr = s_q.baddr;
            endcase
        end
        if (sw_rd_i)
        begin
            case (sw_addr_i)
                phb_pkg::CFG_SEL_ADDR: s_d.rd_o = s_q.sel;
                phb_pkg::CFG_DATA_ADDR: s_d.rd_o = s_q.rdata;
                phb_pkg::BADDR_ADDR: s_d.rd_o = s_q.baddr;
                phb_pkg::WDATA_ADDR: s_d.rd_o = s_q.wdata;
                phb_pkg::RDATA_ADDR: s_d.rd_o = s_q.rdata;
                phb_pkg::STAT_ADDR:
                    s_d.rd_o = {29'h0, s_q.abort, s_q.claimed, s_q.busy};
                default: s_d.rd_o = 32'h0000_0000;
            endcase
        end
        if (s_q.en)
        begin
            case (s_q.st)
                ST_ADDR:
                begin
                    s_d.frame_n = 1'b0;
                    s_d.ad_oe = 1'b1;
                    s_d.st = ST_APH;
                end
                ST_APH:
                begin
                    s_d.irdy_n = 1'b0;
                    s_d.frame_n = s_q.len == 4'h0;
                    s_d.ad_oe = s_q.cmd[0];
                    s_d.ad = s_q.wdata;
                    s_d.wt = 4'h0;
                    s_d.st = ST_DATA;
                end
                ST_DATA:
                begin
                    if (!pci.devsel_n && !pci.trdy_n)
                    begin
                        s_d.claimed = 1'b1;
                        if (!s_q.cmd[0])
                        begin
                            s_d.rdata = pci.ad;
                        end
                        if (s_q.len == 4'h0)
                        begin
                            s_d.frame_n = 1'b1;
                            s_d.irdy_n = 1'b1;
                            s_d.ad_oe = 1'b0;
                            s_d.st = ST_TURN;
                        end
                        else
                        begin
                            // One dword per phase; agent steps its address.
                            s_d.len = s_q.len - 4'h1;
                            s_d.frame_n = s_q.len == 4'h1;
                        end
                    end
                    else if (pci.devsel_n && !s_q.claimed)
                    begin
                        if (s_q.wt == phb_pkg::ABORT_WAIT)
                        begin
                            // Nobody claimed: reads give ones, writes end.
                            s_d.abort = 1'b1;
                            if (!s_q.cmd[0])
                            begin
                                s_d.rdata = phb_pkg::ALL_ONES;
                            end
                            s_d.frame_n = 1'b1;
                            s_d.irdy_n = 1'b1;
                            s_d.ad_oe = 1'b0;
                            s_d.st = ST_TURN;
                        end
                        else
                        begin
                            s_d.wt = s_q.wt + 4'h1;
                        end
                    end
                end
                ST_TURN:
                begin
                    s_d.busy = 1'b0;
                    s_d.idsel = 32'h0000_0000;
                    s_d.st = ST_IDLE;
                end
                default: s_d.st = s_q.st;
            endcase
        end
        // A new cycle starts only when the master is free. It comes after
        // the phase logic so that an idle tick cannot undo the launch.
        if (go && !s_q.busy)
        begin
            s_d.busy = 1'b1;
            s_d.claimed = 1'b0;
            s_d.abort = 1'b0;
            s_d.cmd = go_cmd;
            s_d.ad = go_addr;
            s_d.idsel = go_idsel;
            s_d.len = go_len;
            s_d.st = ST_ADDR;
            if (win_wr)
            begin
                s_d.wdata = sw_wdata_i;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
            s_q.sel <= phb_pkg::SEL_RESET;
            s_q.frame_n <= 1'b1;
            s_q.irdy_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sw_rdata_o = s_q.rd_o;
    assign pci.en = s_q.en;
    assign pci.frame_n = s_q.frame_n;
    assign pci.irdy_n = s_q.irdy_n;
    assign pci.cmd = s_q.cmd;
    assign pci.idsel = s_q.idsel;
    assign pci.ad_h = s_q.ad;
    assign pci.ad_h_oe = s_q.ad_oe;
endmodule

//--- verification/phb_link_chk_sva.sv
// Assertions on the link between host and agent.
`timescale 1ns/100ps
module phb_link_chk (
    input wire logic core_clk_i, // Clock.
    input wire logic srst_i, // Reset.
    input wire logic en, // Link tick.
    input wire logic frame_n, // Frame.
    input wire logic irdy_n, // Host ready.
    input wire logic devsel_n, // Claim.
    input wire logic trdy_n, // Target ready.
    input wire logic [3:0] cmd, // Command.
    input wire logic [31:0] idsel, // Selects.
    input wire logic ad_h_oe, // Host drive.
    input wire logic ad_a_oe, // Agent drive.
    input wire logic [31:0] ad // Resolved lines.
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    // Framing, decoding and ownership of the shared lines.
    cmd_known_a: assert property (
        !frame_n |-> cmd inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB})
        else $error("unknown command");
    idsel_hot_a: assert property (
        !frame_n && cmd[3:1] == 3'h5 |-> $onehot0(idsel))
        else $error("several selects");
    idsel_off_a: assert property (
        !frame_n && cmd[3:1] != 3'h5 |-> idsel == 32'h0)
        else $error("select outside config");
    cfg_addr_a: assert property (
        $fell(frame_n) && cmd[3:1] == 3'h5 && idsel != 32'h0
        |-> ad[31:11] == idsel[31:11] && ad[1:0] == 2'h0)
        else $error("bad config address");
    tick_sync_a: assert property ($fell(frame_n) |-> $past(en))
        else $error("frame off the tick");
    one_owner_a: assert property (!(ad_h_oe && ad_a_oe))
        else $error("both ends drive");
    trdy_claim_a: assert property (!trdy_n |-> !devsel_n)
        else $error("ready without claim");
    claim_data_a: assert property ($fell(devsel_n) |-> !irdy_n)
        else $error("claim before data");
    end_bound_a: assert property ($fell(irdy_n) |-> ##[1:80] irdy_n)
        else $error("cycle never ends");
    // Main scenarios.
    cover property ($fell(devsel_n));
    cover property ($fell(frame_n) && cmd == 4'hA && idsel == 32'h0);
    cover property (!frame_n && cmd == 4'h7);
endmodule

//--- verification/tb.sv
// Bench joining host and agent across the link.
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic [31:0] sel;
        logic wr;
        logic [31:0] data;
        logic [1:0] what;
        logic [31:0] exp;
        logic [2:0] st;
    } phb_row_t;
    // Agent identity word; the value is arbitrary.
    localparam logic [31:0] ID = 32'h3C96_A50F;
    localparam logic [31:0] ONES = 32'hFFFF_FFFF;
    // Select, write, data, result source, expected, status.
    phb_row_t rows [9] = '{
        '{32'h8000_7000, 1'b0, 32'h0, 2'h0, ID, 3'h2},
        '{32'h8000_7004, 1'b1, 32'h1357_9BDF, 2'h1, 32'h1357_9BDF, 3'h2},
        '{32'h8000_7004, 1'b0, 32'h0, 2'h0, 32'h1357_9BDF, 3'h2},
        '{32'h8000_7000, 1'b1, 32'h0, 2'h3, 32'h0, 3'h2},
        '{32'h8000_7000, 1'b0, 32'h0, 2'h0, ID, 3'h2},
        '{32'h8000_2800, 1'b0, 32'h0, 2'h0, ONES, 3'h4},
        '{32'h8000_FF00, 1'b0, 32'h0, 2'h0, ONES, 3'h4},
        '{32'h8001_7001, 1'b0, 32'h0, 2'h0, ONES, 3'h4},
        '{32'h0000_7004, 1'b1, 32'h2468_ACE0, 2'h2, 32'h2468_ACE0, 3'h2}
    };
    logic clk;
    logic rst;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wrs;
    logic rds;
    logic [31:0] rdata;
    logic [31:0] io_reg;
    logic [31:0] w1;
    logic hit;
    logic [31:0] v;
    int n_fail = 0;
    int n_compared = 0;
    int n_hit = 0;
    int h;
    phb_link_if link();
    // Both ends of the link and the checker beside it.
    phb_host phb_host_inst (.core_clk_i(clk), .srst_i(rst),
        .sw_addr_i(addr), .sw_wdata_i(wdata), .sw_wr_i(wrs),
        .sw_rd_i(rds), .sw_rdata_o(rdata), .pci(link));
    phb_agent #(.DEV_NUM(5'h0E), .IO_ADDR(32'h0000_0CFC), .ID_WORD(ID))
    phb_agent_inst (.core_clk_i(clk), .srst_i(rst), .pci(link),
        .io_reg_o(io_reg), .cfg_word1_o(w1), .hit_o(hit));
    phb_link_chk phb_link_chk_inst (.core_clk_i(clk), .srst_i(rst),
        .en(link.en), .frame_n(link.frame_n), .irdy_n(link.irdy_n),
        .devsel_n(link.devsel_n), .trdy_n(link.trdy_n), .cmd(link.cmd),
        .idsel(link.idsel), .ad_h_oe(link.ad_h_oe),
        .ad_a_oe(link.ad_a_oe), .ad(link.ad));
    // Clock of 20 ns.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Counts completed data phases of the agent.
    always @(posedge clk)
        if (hit === 1'b1)
            n_hit <= n_hit + 1;
    task automatic final_report();
        $display("Compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrs <= 1'b1;
        @(posedge clk);
        wrs <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rds <= 1'b1;
        @(posedge clk);
        rds <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Polls the busy flag with a bounded count.
    task automatic idle(output logic [31:0] s);
        for (int k = 0; k < 40; k++)
        begin
            rd(16'h0D10, s);
            if (s[0] === 1'b0)
                return;
        end
        n_fail++;
        final_report();
    endtask
    // Reset, register checks, the table, then a burst.
    initial
    begin
        rst = 1'b1;
        addr = 16'h0;
        wdata = 32'h0;
        wrs = 1'b0;
        rds = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(16'h0CF8, v);
        check(v, 32'h0);
        check(32'(link.frame_n), 32'h1);
        wr(16'h0CF8, ONES);
        rd(16'h0CF8, v);
        check(v, 32'h80FF_FFFF);
        rd(16'h0E00, v);
        check(v, 32'h0);
        foreach (rows[i])
        begin
            wr(16'h0CF8, rows[i].sel);
            if (rows[i].wr)
                wr(16'h0CFC, rows[i].data);
            else
                rd(16'h0CFC, v);
            idle(v);
            check(32'(v[2:0]), 32'(rows[i].st));
            rd(16'h0D0C, v);
            if (rows[i].what == 2'h1)
                v = w1;
            if (rows[i].what == 2'h2)
                v = io_reg;
            if (rows[i].what != 2'h3)
                check(v, rows[i].exp);
        end
        wr(16'h0D04, 32'h000D_0000);
        wr(16'h0D08, 32'h5A5A_C3C3);
        h = n_hit;
        wr(16'h0D00, 32'h0000_0037);
        idle(v);
        check(32'(n_hit - h), 32'h4);
        wr(16'h0D04, 32'h000D_000C);
        wr(16'h0D00, 32'h0000_0005);
        idle(v);
        rd(16'h0D0C, v);
        check(v, 32'h5A5A_C3C3);
        final_report();
    end
endmodule
